//--- inc/pll_ctrl_pkg.sv
// Constants, field layout and types of the loop clock control block.
// Assumes a 10 MHz core clock and an Avalon-MM slave with waitrequest.
package pll_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h0C;
	localparam logic [4:0] OFS_IRQ_EN = 5'h10;
	localparam int CTRL_MULT_BIT = 0;
	localparam int CTRL_RSTEN_BIT = 1;
	localparam int CTRL_PRE_LSB = 4;
	localparam int STAT_FAIL_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_BYP_BIT = 2;
	localparam int STAT_RST_BIT = 3;
	localparam int IRQ_FAIL_BIT = 0;
	localparam int IRQ_LOCK_BIT = 1;
	localparam logic CTRL_MULT_RST = 1'b1;
	localparam logic CTRL_RSTEN_RST = 1'b0;
	localparam logic [2:0] CTRL_PRE_RST = 3'h0;
	localparam logic [1:0] IRQ_EN_RST = 2'h0;
	localparam int MULT_LO = 4;
	localparam int MULT_HI = 8;
	localparam int LOCK_OSC_CYCLES = 4096;
	localparam logic [11:0] LOCK_LAST = 12'(LOCK_OSC_CYCLES - 1);
	localparam int MON_FAIL_NS = 10000;
	localparam int MON_FAIL_CYCLES = MON_FAIL_NS / CLK_PERIOD_NS;
	localparam logic [7:0] MON_LAST = 8'(MON_FAIL_CYCLES - 1);

	typedef enum logic [1:0] {ST_WAIT_OSC, ST_COUNT, ST_RUN} lock_state_t;

	// Feedback counter top for the selected multiplier
	function automatic logic [2:0] mult_top(input logic sel_x4);
		return sel_x4 ? 3'(MULT_LO - 1) : 3'(MULT_HI - 1);
	endfunction : mult_top
endpackage : pll_ctrl_pkg

//--- inc/prescale_if.sv
// Carrier between lock control and the system clock prescaler.
// Assumes both ends run on core_clk.
`timescale 1ns/100ps
interface prescale_if;
	logic src_tick;
	logic hold;
	logic [2:0] divide;
	logic sys_en;
	modport ctrl (output src_tick, output hold, output divide, input sys_en);
	modport div (input src_tick, input hold, input divide, output sys_en);
endinterface : prescale_if

//--- core/system_clock_prescaler.sv
// System clock prescaler: one enable pulse per 1..8 source ticks.
// Assumes src_tick is a one-cycle pulse on core_clk.
`timescale 1ns/100ps
module system_clock_prescaler import pll_ctrl_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	prescale_if.div pif
);
	typedef struct packed {
		logic [2:0] cnt;
		logic [2:0] div;
		logic en;
	} pre_state_t;

	pre_state_t r;
	pre_state_t n;

	always_comb begin
		n = r;
		n.en = 1'b0;
		if (pif.hold) begin
			n.cnt = 3'h0;
			n.div = pif.divide;
		end else if (pif.src_tick) begin
			// New divide taken at the period boundary here, and also while held above
			if (r.cnt >= r.div) begin
				n.cnt = 3'h0;
				n.div = pif.divide;
				n.en = 1'b1;
			end else begin
				n.cnt = r.cnt + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r <= '0;
		end else if (clk_en) begin
			r <= n;
		end
	end

	assign pif.sys_en = r.en;

	a_hold_silence: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && pif.hold |=> !pif.sys_en)
		else $error("clock pulse while held");
	a_div_midperiod: assert property (@(posedge core_clk) disable iff (srst)
		clk_en && !pif.hold && pif.src_tick && r.cnt < r.div
		|=> !pif.sys_en && $stable(r.div))
		else $error("divide changed inside a period");
endmodule : system_clock_prescaler

//--- core/pll_clock_source_control.sv
// Digital control of a loop clock source: feedback divider, bypass
// select, lock delay, oscillator monitor, prescaler and registers.
// Assumes analog loop and oscillator outside; pins are asynchronous.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module pll_clock_source_control import pll_ctrl_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic clk_en,
	input wire logic crystal_input_pin,
	input wire logic loop_osc_pin,
	input wire logic loop_bypass_pin,
	input wire logic halt_req,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic system_clock_en,
	output logic system_reset,
	output logic loop_feedback,
	output logic loop_multiplier_x8,
	output logic loop_osc_enable,
	output logic irq
);
	typedef struct packed {
		logic xtal_s1;
		logic xtal_s2;
		logic xtal_d;
		logic vco_s1;
		logic vco_s2;
		logic vco_d;
		logic byp_s1;
		logic byp_s2;
		lock_state_t state;
		logic [11:0] lock_cnt;
		logic [7:0] mon_cnt;
		logic osc_bad;
		logic [2:0] fb_cnt;
		logic fb_out;
		logic mult;
		logic rst_en;
		logic [2:0] pre;
		logic fail_flag;
		logic rst_out;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic ack;
		logic [31:0] rdata;
	} core_state_t;

	core_state_t r;
	core_state_t n;
	logic xtal_rise;
	logic xtal_edge;
	logic vco_rise;
	logic req;
	logic done;
	logic wr;
	logic fail_evt;
	logic lock_evt;
	logic mult_chg;
	logic clr_fail;
	logic [1:0] irq_clr;

	prescale_if pif ();

	assign xtal_rise = r.xtal_s2 & ~r.xtal_d;
	assign xtal_edge = r.xtal_s2 ^ r.xtal_d;
	assign vco_rise = r.vco_s2 & ~r.vco_d;
	assign req = avs_read | avs_write;
	assign done = req & r.ack;
	assign wr = done & avs_write & avs_byteenable[0];
	assign avs_waitrequest = req & ~r.ack;

	always_comb begin
		n = r;
		fail_evt = 1'b0;
		lock_evt = 1'b0;
		mult_chg = 1'b0;
		clr_fail = 1'b0;
		irq_clr = 2'h0;
		n.xtal_s1 = crystal_input_pin;
		n.xtal_s2 = r.xtal_s1;
		n.xtal_d = r.xtal_s2;
		n.vco_s1 = loop_osc_pin;
		n.vco_s2 = r.vco_s1;
		n.vco_d = r.vco_s2;
		n.byp_s1 = loop_bypass_pin;
		n.byp_s2 = r.byp_s1;

		// Missing edges for too long, incl. stuck high or low
		if (xtal_edge) begin
			n.mon_cnt = 8'h00;
			n.osc_bad = 1'b0;
		end else if (r.mon_cnt >= MON_LAST) begin
			n.osc_bad = 1'b1;
		end else begin
			n.mon_cnt = r.mon_cnt + 8'h01;
		end
		fail_evt = n.osc_bad & ~r.osc_bad;

		// Feedback divider: one pulse per M loop cycles
		n.fb_out = 1'b0;
		if (vco_rise && !r.byp_s2) begin
			if (r.fb_cnt >= mult_top(r.mult)) begin
				n.fb_cnt = 3'h0;
				n.fb_out = 1'b1;
			end else begin
				n.fb_cnt = r.fb_cnt + 3'h1;
			end
		end

		// Register access, one wait state
		n.ack = req & ~r.ack;
		if (req && !r.ack) begin
			n.rdata = 32'h00000000;
			case (avs_address)
				OFS_CTRL: begin
					n.rdata[CTRL_MULT_BIT] = r.mult;
					n.rdata[CTRL_RSTEN_BIT] = r.rst_en;
					n.rdata[CTRL_PRE_LSB +: 3] = r.pre;
				end
				OFS_STATUS: begin
					n.rdata[STAT_FAIL_BIT] = r.fail_flag;
					n.rdata[STAT_RUN_BIT] = (r.state == ST_RUN);
					n.rdata[STAT_BYP_BIT] = r.byp_s2;
					n.rdata[STAT_RST_BIT] = r.rst_out;
				end
				OFS_IRQ_STAT: n.rdata[1:0] = r.irq_stat;
				OFS_IRQ_EN: n.rdata[1:0] = r.irq_en;
				default: n.rdata = 32'h00000000;
			endcase
		end
		if (wr) begin
			case (avs_address)
				OFS_CTRL: begin
					n.mult = avs_writedata[CTRL_MULT_BIT];
					n.rst_en = avs_writedata[CTRL_RSTEN_BIT];
					n.pre = avs_writedata[CTRL_PRE_LSB +: 3];
					mult_chg = n.mult != r.mult;
				end
				OFS_STATUS: clr_fail = avs_writedata[STAT_FAIL_BIT];
				OFS_IRQ_CLR: irq_clr = avs_writedata[1:0];
				OFS_IRQ_EN: n.irq_en = avs_writedata[1:0];
				default: n.irq_en = r.irq_en;
			endcase
		end

		// Lock delay control
		case (r.state)
			ST_WAIT_OSC: begin
				if (!halt_req && !r.osc_bad && xtal_rise) begin
					n.state = ST_COUNT;
					n.lock_cnt = 12'h000;
				end
			end
			ST_COUNT: begin
				if (xtal_rise) begin
					if (r.lock_cnt == LOCK_LAST) begin
						n.state = ST_RUN;
						n.rst_out = 1'b0;
						lock_evt = 1'b1;
					end else begin
						n.lock_cnt = r.lock_cnt + 12'h001;
					end
				end
			end
			ST_RUN: n.state = ST_RUN;
			default: n.state = ST_WAIT_OSC;
		endcase
		if (mult_chg && r.state != ST_WAIT_OSC) begin
			n.state = ST_COUNT;
			n.lock_cnt = 12'h000;
			lock_evt = 1'b0;
		end
		if (halt_req || n.osc_bad) begin
			n.state = ST_WAIT_OSC;
			lock_evt = 1'b0;
		end
		if (fail_evt && r.rst_en) begin
			n.rst_out = 1'b1;
		end

		// Set wins over a clear in the same cycle
		n.fail_flag = fail_evt | (r.fail_flag & ~clr_fail);
		n.irq_stat[IRQ_FAIL_BIT] = fail_evt |
			(r.irq_stat[IRQ_FAIL_BIT] & ~irq_clr[IRQ_FAIL_BIT]);
		n.irq_stat[IRQ_LOCK_BIT] = lock_evt |
			(r.irq_stat[IRQ_LOCK_BIT] & ~irq_clr[IRQ_LOCK_BIT]);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			r <= '0;
			r.mult <= CTRL_MULT_RST;
			r.rst_en <= CTRL_RSTEN_RST;
			r.pre <= CTRL_PRE_RST;
			r.irq_en <= IRQ_EN_RST;
			r.rst_out <= 1'b1;
		end else if (clk_en) begin
			r <= n;
		end
	end

	// Bypass high takes the oscillator, low the gated loop output
	assign pif.src_tick = r.byp_s2 ? xtal_rise : vco_rise;
	assign pif.hold = (r.state != ST_RUN);
	assign pif.divide = r.pre;

	system_clock_prescaler u_prescaler (
		.core_clk(core_clk),
		.srst(srst),
		.clk_en(clk_en),
		.pif(pif)
	);

	assign system_clock_en = pif.sys_en;
	assign system_reset = r.rst_out;
	assign loop_feedback = r.fb_out;
	assign loop_multiplier_x8 = ~r.mult;
	assign loop_osc_enable = ~r.byp_s2;
	assign avs_readdata = r.rdata;
	assign irq = |(r.irq_stat & r.irq_en);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence last_osc_s;
		clk_en && r.state == ST_COUNT && r.lock_cnt == LOCK_LAST
			&& xtal_rise && !halt_req && !n.osc_bad && !mult_chg;
	endsequence
	sequence released_s;
		r.state == ST_RUN && !system_reset;
	endsequence

	a_lock_release: assert property (last_osc_s |=> released_s)
		else $error("no release after lock count");
	a_held_no_clock: assert property (
		clk_en && r.state != ST_RUN |=> !system_clock_en)
		else $error("system clock ran before lock");
	a_bypass_route: assert property (
		r.byp_s2 |-> pif.src_tick == xtal_rise)
		else $error("bypass did not route oscillator");
	a_fb_modulus: assert property (
		clk_en && vco_rise && !r.byp_s2 && r.fb_cnt == mult_top(r.mult)
		|=> loop_feedback ##1 (!loop_feedback || !$past(clk_en)))
		else $error("feedback pulse missing at modulus");
	a_fail_flag_set: assert property (
		clk_en && fail_evt |=> r.fail_flag && r.state == ST_WAIT_OSC)
		else $error("failure not flagged");
	a_fail_reset_on: assert property (
		clk_en && fail_evt && r.rst_en |=> system_reset)
		else $error("no reset on oscillator failure");
	a_fail_reset_off: assert property (
		clk_en && fail_evt && !r.rst_en && !r.rst_out |=> !system_reset)
		else $error("reset forced while option off");
	a_flag_sticky: assert property (
		clk_en && r.fail_flag && !clr_fail |=> r.fail_flag)
		else $error("failure flag dropped");
	a_mult_relock: assert property (
		clk_en && mult_chg && r.state == ST_RUN && !halt_req && !n.osc_bad
		|=> r.state == ST_COUNT && r.lock_cnt == 12'h000)
		else $error("multiplier change did not restart delay");
endmodule : pll_clock_source_control

//--- dv/osc_model.sv
// Reference crystal and loop oscillator model for the clock block.
// Assumes core_clk runs; edges are launched just after its rise.
`timescale 1ns/100ps
module osc_model (
	input wire logic core_clk,
	input wire logic stop,
	output logic crystal_input_pin,
	output logic loop_osc_pin
);
	logic [1:0] cnt_r = 2'h0;
	initial crystal_input_pin = 1'b0;
	initial loop_osc_pin = 1'b0;
	// Crystal period 4 core cycles, loop oscillator period 2
	always @(posedge core_clk) begin
		cnt_r <= cnt_r + 2'h1;
		loop_osc_pin <= ~loop_osc_pin;
		if (!stop && cnt_r[0]) begin
			crystal_input_pin <= ~crystal_input_pin;
		end
	end
endmodule : osc_model

//--- dv/tb.sv
// Self-checking bench of the loop clock control block.
// Assumes the design's one-wait-state Avalon-MM slave.
`timescale 1ns/100ps
module tb;
	import pll_ctrl_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic xtal_stop = 1'b0;
	logic byp = 1'b0;
	logic halt = 1'b0;
	logic fb, x8, osc_en;
	logic crystal_input_pin, loop_osc_pin;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd;
	logic avs_waitrequest, system_clock_en, system_reset, irq;
	int failures = 0;
	int compares = 0;
	int n;

	pll_clock_source_control pll_clock_source_control_inst (
		.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
		.crystal_input_pin(crystal_input_pin),
		.loop_osc_pin(loop_osc_pin), .loop_bypass_pin(byp),
		.halt_req(halt), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'h1),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.system_clock_en(system_clock_en), .system_reset(system_reset),
		.loop_feedback(fb), .loop_multiplier_x8(x8),
		.loop_osc_enable(osc_en),
		.irq(irq));
	osc_model osc_model_inst (.core_clk(core_clk), .stop(xtal_stop),
		.crystal_input_pin(crystal_input_pin),
		.loop_osc_pin(loop_osc_pin));

	initial begin
		forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end

	task automatic end_of_test();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Waits at falling edges for a level, bounded
	task automatic wait_lvl(ref logic s, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (s !== v && n < lim);
		if (s !== v) begin
			failures++;
			end_of_test();
		end
	endtask : wait_lvl

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// Waitrequest and read data taken as they stand before each edge
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			end_of_test();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	// Pulse spacing, after one pulse that takes up a new setting
	task automatic period(ref logic s, input int exp);
		wait_lvl(s, 1'b1, 300);
		wait_lvl(s, 1'b0, 300);
		wait_lvl(s, 1'b1, 300);
		wait_lvl(s, 1'b0, 300);
		wait_lvl(s, 1'b1, 300);
		chk(32'(n + 1), 32'(exp));
	endtask : period

	initial begin
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		bus(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h1);
		bus(1'b0, OFS_IRQ_EN, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 5'h14, 32'h0);
		chk(rd, 32'h0);
		@(negedge core_clk);
		chk(32'(system_reset), 32'h1);
		chk(32'(x8), 32'h0);
		repeat (LOCK_OSC_CYCLES * 3) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(system_reset), 32'h1);
		wait_lvl(system_reset, 1'b0, LOCK_OSC_CYCLES * 2);
		bus(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h2);
		chk(32'(irq), 32'h0);
		chk(32'(osc_en), 32'h1);
		period(fb, 8);
		// x8 while running, halt, then a failure with reset option off
		bus(1'b1, OFS_CTRL, 32'h0);
		@(negedge core_clk);
		chk(32'(x8), 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		@(posedge core_clk);
		halt <= 1'b1;
		repeat (10) @(posedge core_clk);
		halt <= 1'b0;
		bus(1'b1, OFS_IRQ_EN, 32'h1);
		xtal_stop <= 1'b1;
		wait_lvl(irq, 1'b1, 300);
		chk(32'(system_reset), 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		xtal_stop <= 1'b0;
		bus(1'b1, OFS_STATUS, 32'h1);
		bus(1'b1, OFS_IRQ_CLR, 32'h3);
		repeat (LOCK_OSC_CYCLES * 3) @(posedge core_clk);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		wait_lvl(system_clock_en, 1'b1, LOCK_OSC_CYCLES * 2);
		bus(1'b0, OFS_IRQ_STAT, 32'h0);
		chk(rd, 32'h2);
		period(fb, 16);
		// Divide by 3 from loop, then from bypassed crystal
		bus(1'b1, OFS_CTRL, 32'h20);
		period(system_clock_en, 6);
		@(posedge core_clk);
		byp <= 1'b1;
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		chk(32'(osc_en), 32'h0);
		period(system_clock_en, 12);
		bus(1'b1, OFS_CTRL, 32'h70);
		period(system_clock_en, 32);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h6);
		// Crystal stops with reset option on
		bus(1'b1, OFS_IRQ_CLR, 32'h3);
		bus(1'b1, OFS_IRQ_EN, 32'h1);
		bus(1'b1, OFS_CTRL, 32'h2);
		xtal_stop <= 1'b1;
		wait_lvl(irq, 1'b1, 300);
		chk(32'(system_reset), 32'h1);
		@(posedge core_clk);
		xtal_stop <= 1'b0;
		repeat (50) @(posedge core_clk);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd[STAT_FAIL_BIT]), 32'h1);
		bus(1'b1, OFS_STATUS, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rd[STAT_FAIL_BIT]), 32'h0);
		bus(1'b1, OFS_IRQ_CLR, 32'h1);
		@(negedge core_clk);
		chk(32'(irq), 32'h0);
		end_of_test();
	end
endmodule : tb
